/* gtu_pkg.sv */
// gtu_pkg: constants shared by the three-timer counter block
// assumes a 125 MHz system clock and a 32-bit classic wishbone slave
package gtu_pkg;

    ////////////////////////////////////////////////////////////////////
    // widths and timing
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned CFG_W      = 16;
    localparam int unsigned DIV_W      = 10;
    localparam int unsigned PS_W       = 3;
    localparam int unsigned SYS_CLK_HZ = 125_000_000;
    // finest counting step, in system clock cycles
    localparam int unsigned RES_CYC    = 4;
    localparam logic [1:0]  RES_LAST   = 2'(RES_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CORE_CFG = 8'h00;
    localparam logic [7:0] OFS_CORE_CNT = 8'h04;
    localparam logic [7:0] OFS_AUXL_CFG = 8'h08;
    localparam logic [7:0] OFS_AUXL_CNT = 8'h0C;
    localparam logic [7:0] OFS_AUXH_CFG = 8'h10;
    localparam logic [7:0] OFS_AUXH_CNT = 8'h14;
    localparam logic [7:0] OFS_STAT     = 8'h18;

    ////////////////////////////////////////////////////////////////////
    // configuration field positions
    localparam int unsigned F_MODE   = 0;
    localparam int unsigned F_RUN    = 2;
    localparam int unsigned F_DOWN   = 3;
    localparam int unsigned F_EXTDIR = 4;
    localparam int unsigned F_GPOL   = 5;
    localparam int unsigned F_EDGE   = 6;
    localparam int unsigned F_PS     = 8;
    localparam int unsigned F_SRC    = 11;
    localparam int unsigned F_FUNC   = 12;
    localparam int unsigned F_OUTEN  = 12;
    localparam int unsigned F_TRIG   = 14;
    // status register bits
    localparam int unsigned S_LATCH  = 0;
    localparam int unsigned S_PIN0   = 1;

    ////////////////////////////////////////////////////////////////////
    // encodings and reset values
    localparam logic [1:0] MODE_TMR  = 2'h0;
    localparam logic [1:0] MODE_GATE = 2'h1;
    localparam logic [1:0] MODE_CNT  = 2'h2;
    localparam logic [1:0] MODE_INC  = 2'h3;
    localparam logic [1:0] FUNC_NONE = 2'h0;
    localparam logic [1:0] FUNC_CAP  = 2'h1;
    localparam logic [1:0] FUNC_RLD  = 2'h2;
    localparam logic [1:0] TRIG_PIN_R  = 2'h0;
    localparam logic [1:0] TRIG_PIN_F  = 2'h1;
    localparam logic [1:0] TRIG_LAT_R  = 2'h2;
    localparam logic [1:0] TRIG_LAT_F  = 2'h3;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // edge select: bit 0 takes rising, bit 1 takes falling
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       rise,
                                      input logic       fall);
        return (sel[0] & rise) | (sel[1] & fall);
    endfunction

endpackage

/* gtu_sensor.sv */
// gtu_sensor: event, gate and quadrature sensor on the timer pins
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module gtu_sensor (
    input  wire logic clk_i,
    output logic      a_o = 1'b0,
    output logic      b_o = 1'b0,
    output logic      aux_o = 1'b0
);
    logic [1:0] gray [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    int         idx = 0;
    // each level outlasts the pin filter and two sampling ticks
    task automatic set_pins(input logic a, input logic b, input logic x);
        @(posedge clk_i);
        a_o   <= a;
        b_o   <= b;
        aux_o <= x;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic pulse_a(input int n);
        repeat (n) begin
            set_pins(1'b1, b_o, aux_o);
            set_pins(1'b0, b_o, aux_o);
        end
    endtask
    task automatic pulse_aux();
        set_pins(a_o, b_o, 1'b1);
        set_pins(a_o, b_o, 1'b0);
    endtask
    task automatic quad(input int n);
        repeat (n < 0 ? -n : n) begin
            idx = (idx + (n > 0 ? 1 : 3)) % 4;
            set_pins(gray[idx][1], gray[idx][0], aux_o);
        end
    endtask
endmodule

/* gtu_timer.sv */
// gtu_timer: one 16-bit up/down timer with four counting modes
// assumes filtered pin levels and a shared free-running divider
`timescale 1ns/1ps
module gtu_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    gtu_tmr_if.tmr   tif
);
    logic [15:0] cnt_ff;
    logic        a_ff;
    logic        b_ff;
    logic        evp_ff;
    logic [1:0]  mode;
    logic [7:0]  pmask;
    logic        base_tick;
    logic        pre_tick;
    logic        a_chg;
    logic        b_chg;
    logic        step;
    logic        down;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        mode      = tif.cfg[gtu_pkg::F_MODE +: 2];
        pmask     = (8'h01 << tif.cfg[gtu_pkg::F_PS +: gtu_pkg::PS_W])
                    - 8'h01;
        // one step per four cycles at most
        base_tick = tif.div[1:0] == gtu_pkg::RES_LAST;
        pre_tick  = base_tick & ((tif.div[9:2] & pmask) == pmask);
        a_chg     = tif.in_lvl ^ a_ff;
        b_chg     = tif.dir_lvl ^ b_ff;
        case (mode)
            gtu_pkg::MODE_TMR:  step = pre_tick;
            gtu_pkg::MODE_GATE: step = pre_tick &
                (tif.in_lvl == tif.cfg[gtu_pkg::F_GPOL]);
            gtu_pkg::MODE_CNT:  step = base_tick &
                (tif.cfg[gtu_pkg::F_SRC] ? evp_ff :
                 gtu_pkg::edge_hit(tif.cfg[gtu_pkg::F_EDGE +: 2],
                                   a_chg & tif.in_lvl,
                                   a_chg & ~tif.in_lvl));
            // a both-lines change is illegal and skipped
            gtu_pkg::MODE_INC:  step = base_tick & (a_chg ^ b_chg);
            default:            step = 1'b0;
        endcase
        // halted while acting as capture or reload
        step = step & tif.cfg[gtu_pkg::F_RUN] & ~tif.halt;
        // software or pin direction, quadrature phase
        if (mode == gtu_pkg::MODE_INC) begin
            down = ~(tif.in_lvl ^ b_ff) ^ tif.cfg[gtu_pkg::F_DOWN];
        end else begin
            down = tif.cfg[gtu_pkg::F_DOWN] ^
                   (tif.cfg[gtu_pkg::F_EXTDIR] & tif.dir_lvl);
        end
    end

    // wrap flags, independent of a load to avoid a loop
    assign tif.ovf = step & ~down & (&cnt_ff);
    assign tif.unf = step & down & ~(|cnt_ff);
    assign tif.cnt = cnt_ff;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_ff <= 1'b0;
            b_ff <= 1'b0;
        end else if (base_tick) begin
            a_ff <= tif.in_lvl;
            b_ff <= tif.dir_lvl;
        end
    end

    // a latch event arriving on a tick is kept for the next tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evp_ff <= 1'b0;
        end else begin
            evp_ff <= tif.aux_evt | (evp_ff & ~base_tick);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= gtu_pkg::CNT_RST;
        end else if (tif.ld) begin
            cnt_ff <= tif.ld_val;
        end else if (step) begin
            cnt_ff <= down ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
        end
    end

endmodule

/* gtu_tmr_if.sv */
// gtu_tmr_if: links the control logic to one 16-bit timer
// assumes every signal is on the system clock
`timescale 1ns/1ps
interface gtu_tmr_if;
    logic [15:0] cfg;
    logic [9:0]  div;
    logic        in_lvl;
    logic        dir_lvl;
    logic        aux_evt;
    logic        halt;
    logic        ld;
    logic [15:0] ld_val;
    logic [15:0] cnt;
    logic        ovf;
    logic        unf;

    modport ctrl (output cfg, div, in_lvl, dir_lvl, aux_evt, halt, ld,
                  output ld_val, input cnt, ovf, unf);
    modport tmr  (input cfg, div, in_lvl, dir_lvl, aux_evt, halt, ld,
                  input ld_val, output cnt, ovf, unf);
endinterface

/* gtu_top.sv */
// gtu_top: core timer plus two auxiliary timers on a wishbone slave
// assumes a classic wishbone master and asynchronous pin inputs
//
// Contract
// - three timers, each sixteen bits wide
// - each timer picks one of four modes
// - timer mode counts prescaled system clock
// - counter mode counts input pin events
// - gated mode counts only while gate active
// - at most one step per four cycles
// - direction from software or direction pin
// - quadrature A/B decoded into position count
// - toggle latch flips on core wrap
// - toggle latch optionally drives output pin
// - toggle latch can clock auxiliary timers
// - timers may be concatenated within module
// - capture or reload auxiliary timer halts
// - capture copies core count on input event
// - reload loads core on pin/latch event
// - opposite-edge reloads alternate for PWM
// - low aux input and aux directions unconnected
`timescale 1ns/1ps
module gtu_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        core_gate_clk_i,
    input  wire logic        core_dir_i,
    input  wire logic        auxh_gate_clk_i,
    output logic             toggle_latch_pin_o
);
    localparam int unsigned NPIN = 3;
    localparam int unsigned P_CIN = 0;
    localparam int unsigned P_CDIR = 1;
    localparam int unsigned P_HIN = 2;

    gtu_tmr_if core_if ();
    gtu_tmr_if auxl_if ();
    gtu_tmr_if auxh_if ();

    logic [NPIN-1:0] s1_ff;
    logic [NPIN-1:0] s2_ff;
    logic [NPIN-1:0] s3_ff;
    logic [NPIN-1:0] flt_ff;
    logic [NPIN-1:0] prv_ff;
    logic [NPIN-1:0] p_rise;
    logic [NPIN-1:0] p_fall;

    logic [9:0]  div_ff;
    logic [15:0] core_cfg_ff;
    logic [15:0] auxl_cfg_ff;
    logic [15:0] auxh_cfg_ff;
    logic        latch_ff;
    logic        ack_ff;
    logic [31:0] rdat_ff;

    logic        req;
    logic        wr;
    logic [15:0] wval;
    logic [15:0] nxt_rdat;
    logic        wr_core_cnt;
    logic        wr_auxl_cnt;
    logic        wr_auxh_cnt;
    logic        wr_stat;
    logic        flip;
    logic        lat_rise;
    logic        lat_fall;
    logic        l_cap;
    logic        h_cap;
    logic        l_rld;
    logic        h_rld;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; a level is accepted when stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= {auxh_gate_clk_i, core_dir_i, core_gate_clk_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_ff <= '0;
            prv_ff <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    flt_ff[i] <= s3_ff[i];
                end
            end
            prv_ff <= flt_ff;
        end
    end

    assign p_rise = flt_ff & ~prv_ff;
    assign p_fall = ~flt_ff & prv_ff;

    ////////////////////////////////////////////////////////////////////
    // shared divider; bits 1:0 set the four-cycle base step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, unmapped reads give zero
    assign req      = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr       = req & wb_we_i;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0]  sel);
        return {sel[1] ? dat[15:8] : old[15:8],
                sel[0] ? dat[7:0]  : old[7:0]};
    endfunction

    always_comb begin
        wr_core_cnt = wr & (wb_adr_i == gtu_pkg::OFS_CORE_CNT);
        wr_auxl_cnt = wr & (wb_adr_i == gtu_pkg::OFS_AUXL_CNT);
        wr_auxh_cnt = wr & (wb_adr_i == gtu_pkg::OFS_AUXH_CNT);
        wr_stat     = wr & (wb_adr_i == gtu_pkg::OFS_STAT) & wb_sel_i[0];
        wval        = wb_dat_i[15:0];
        case (wb_adr_i)
            gtu_pkg::OFS_CORE_CFG: nxt_rdat = core_cfg_ff;
            gtu_pkg::OFS_CORE_CNT: nxt_rdat = core_if.cnt;
            gtu_pkg::OFS_AUXL_CFG: nxt_rdat = auxl_cfg_ff;
            gtu_pkg::OFS_AUXL_CNT: nxt_rdat = auxl_if.cnt;
            gtu_pkg::OFS_AUXH_CFG: nxt_rdat = auxh_cfg_ff;
            gtu_pkg::OFS_AUXH_CNT: nxt_rdat = auxh_if.cnt;
            gtu_pkg::OFS_STAT:     nxt_rdat = {12'h000, flt_ff, latch_ff};
            default:               nxt_rdat = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            // read data stands until the next read, writes leave it alone
            if (req & ~wb_we_i) begin
                rdat_ff <= {16'h0000, nxt_rdat};
            end
        end
    end

    // each timer has its own configuration word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_cfg_ff <= gtu_pkg::CFG_RST;
            auxl_cfg_ff <= gtu_pkg::CFG_RST;
            auxh_cfg_ff <= gtu_pkg::CFG_RST;
        end else if (wr) begin
            case (wb_adr_i)
                gtu_pkg::OFS_CORE_CFG:
                    core_cfg_ff <= merge(core_cfg_ff, wval, wb_sel_i[1:0]);
                gtu_pkg::OFS_AUXL_CFG:
                    auxl_cfg_ff <= merge(auxl_cfg_ff, wval, wb_sel_i[1:0]);
                gtu_pkg::OFS_AUXH_CFG:
                    auxh_cfg_ff <= merge(auxh_cfg_ff, wval, wb_sel_i[1:0]);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // toggle latch
    // flip on core overflow or underflow
    assign flip     = core_if.ovf | core_if.unf;
    assign lat_rise = flip & ~latch_ff;
    assign lat_fall = flip & latch_ff;

    // a software write and a wrap in one cycle: the wrap still flips
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_ff <= 1'b0;
        end else if (wr_stat) begin
            latch_ff <= wb_dat_i[gtu_pkg::S_LATCH] ^ flip;
        end else if (flip) begin
            latch_ff <= ~latch_ff;
        end
    end

    // drive latch onto pin when enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_latch_pin_o <= 1'b0;
        end else begin
            toggle_latch_pin_o <= latch_ff & core_cfg_ff[gtu_pkg::F_OUTEN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // capture and reload events for the auxiliary timers
    function automatic logic rld_hit(input logic [1:0] trig,
                                     input logic       prise,
                                     input logic       pfall,
                                     input logic       lrise,
                                     input logic       lfall);
        case (trig)
            gtu_pkg::TRIG_PIN_R: return prise;
            gtu_pkg::TRIG_PIN_F: return pfall;
            gtu_pkg::TRIG_LAT_R: return lrise;
            default:             return lfall;
        endcase
    endfunction

    always_comb begin
        // low aux input has no pin, it never fires
        // capture on the aux input's selected edge
        l_cap = 1'b0;
        h_cap = (auxh_cfg_ff[gtu_pkg::F_FUNC +: 2] == gtu_pkg::FUNC_CAP) &
                gtu_pkg::edge_hit(auxh_cfg_ff[gtu_pkg::F_EDGE +: 2],
                                  p_rise[P_HIN], p_fall[P_HIN]);
        // reload on pin edge or latch transition
        l_rld = (auxl_cfg_ff[gtu_pkg::F_FUNC +: 2] == gtu_pkg::FUNC_RLD) &
                rld_hit(auxl_cfg_ff[gtu_pkg::F_TRIG +: 2], 1'b0, 1'b0,
                        lat_rise, lat_fall);
        h_rld = (auxh_cfg_ff[gtu_pkg::F_FUNC +: 2] == gtu_pkg::FUNC_RLD) &
                rld_hit(auxh_cfg_ff[gtu_pkg::F_TRIG +: 2],
                        p_rise[P_HIN], p_fall[P_HIN], lat_rise, lat_fall);
    end

    ////////////////////////////////////////////////////////////////////
    // core timer hookup
    assign core_if.cfg     = core_cfg_ff;
    assign core_if.div     = div_ff;
    assign core_if.in_lvl  = flt_ff[P_CIN];
    assign core_if.dir_lvl = flt_ff[P_CDIR];
    assign core_if.aux_evt = 1'b0;
    assign core_if.halt    = 1'b0;
    // a software write wins, then low reload, then high
    assign core_if.ld      = wr_core_cnt | l_rld | h_rld;
    assign core_if.ld_val  = wr_core_cnt ? merge(core_if.cnt, wval,
                                                 wb_sel_i[1:0]) :
                             l_rld ? auxl_if.cnt : auxh_if.cnt;

    // low auxiliary timer hookup
    // no input pin and no direction pin
    assign auxl_if.cfg     = auxl_cfg_ff;
    assign auxl_if.div     = div_ff;
    assign auxl_if.in_lvl  = 1'b0;
    assign auxl_if.dir_lvl = 1'b0;
    // latch transitions clock the concatenated timer
    assign auxl_if.aux_evt = gtu_pkg::edge_hit(
                                 auxl_cfg_ff[gtu_pkg::F_EDGE +: 2],
                                 lat_rise, lat_fall);
    // stopped while used as capture or reload
    assign auxl_if.halt    = auxl_cfg_ff[gtu_pkg::F_FUNC +: 2]
                             != gtu_pkg::FUNC_NONE;
    assign auxl_if.ld      = wr_auxl_cnt | l_cap;
    assign auxl_if.ld_val  = wr_auxl_cnt ? merge(auxl_if.cnt, wval,
                                                 wb_sel_i[1:0]) :
                             core_if.cnt;

    // high auxiliary timer hookup
    assign auxh_if.cfg     = auxh_cfg_ff;
    assign auxh_if.div     = div_ff;
    assign auxh_if.in_lvl  = flt_ff[P_HIN];
    assign auxh_if.dir_lvl = 1'b0;
    assign auxh_if.aux_evt = gtu_pkg::edge_hit(
                                 auxh_cfg_ff[gtu_pkg::F_EDGE +: 2],
                                 lat_rise, lat_fall);
    assign auxh_if.halt    = auxh_cfg_ff[gtu_pkg::F_FUNC +: 2]
                             != gtu_pkg::FUNC_NONE;
    assign auxh_if.ld      = wr_auxh_cnt | h_cap;
    assign auxh_if.ld_val  = wr_auxh_cnt ? merge(auxh_if.cnt, wval,
                                                 wb_sel_i[1:0]) :
                             core_if.cnt;

    ////////////////////////////////////////////////////////////////////
    // three identical 16-bit timers
    gtu_timer u_core (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (core_if.tmr)
    );

    gtu_timer u_auxl (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (auxl_if.tmr)
    );

    gtu_timer u_auxh (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tif   (auxh_if.tmr)
    );

endmodule

/* gtu_top_asserts.sv */
// gtu_top_asserts: bus and pin checks for the three-timer block
// assumes it is bound to gtu_top and sees only that module's ports
`timescale 1ns/1ps
module gtu_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        core_gate_clk_i,
    input wire logic        core_dir_i,
    input wire logic        auxh_gate_clk_i,
    input wire logic        toggle_latch_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    logic take_rd;
    assign take_rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_far;
        take_rd && wb_adr_i > 8'h18;
    endsequence
    sequence s_rd_stat;
        take_rd && wb_adr_i == 8'h18;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_ack_follows_req: assert property (s_req |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property
        ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_dat_hold: assert property (!take_rd |=> $stable(wb_dat_o))
        else $error("read data moved without a read");
    a_upper_zero: assert property
        (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_far_read_zero: assert property (s_rd_far |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_stat_bits: assert property
        (s_rd_stat |=> wb_dat_o[15:4] == 12'h000)
        else $error("status has extra bits");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !toggle_latch_pin_o && wb_dat_o == 32'h0)
        else $error("outputs not cleared by reset");
endmodule
bind gtu_top gtu_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_gate_clk_i(core_gate_clk_i), .core_dir_i(core_dir_i),
    .auxh_gate_clk_i(auxh_gate_clk_i),
    .toggle_latch_pin_o(toggle_latch_pin_o));

/* gtu_top_tb.sv */
// gtu_top_tb: self-checking bench for the three-timer block
// assumes a 125 MHz clock and the sensor model on the pins
`timescale 1ns/1ps
module gtu_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pin_a;
    logic        pin_b;
    logic        pin_aux;
    logic        toggle_latch_pin_o;
    logic [31:0] exp_q [$];
    bit          chk_q [$];
    logic [31:0] rv;
    logic [31:0] v;
    int          fails = 0;
    int          num_checks = 0;
    int          n;
    integer      seed = 32'h89a0d454;

    always #4 clk_i = ~clk_i;

    gtu_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .core_gate_clk_i(pin_a), .core_dir_i(pin_b),
        .auxh_gate_clk_i(pin_aux), .toggle_latch_pin_o(toggle_latch_pin_o));
    gtu_sensor u_sen (.clk_i(clk_i), .a_o(pin_a), .b_o(pin_b),
        .aux_o(pin_aux));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // request held until ack is sampled, then dropped for a cycle
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] d, input logic [3:0] sel);
        int t;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        if (wb_ack_o !== 1'b1)
            fails++;
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        bus(1'b1, adr, d, 4'hF);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] e,
                      input bit c = 1'b1);
        exp_q.push_back(e);
        chk_q.push_back(c);
        bus(1'b0, adr, 32'h0, 4'hF);
    endtask
    task automatic wait_pin(input logic lvl, output int k);
        k = 0;
        while (toggle_latch_pin_o !== lvl && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        if (toggle_latch_pin_o !== lvl)
            fails++;
    endtask
    // oldest note meets the read data in the ack cycle
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            v = exp_q.pop_front();
            if (chk_q.pop_front())
                check(wb_dat_o, v);
        end
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 28; a += 4)
            rd(8'(a), 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, $random(seed));
            rd(8'h04, {16'h0000, wb_dat_i[15:0]});
        end
        bus(1'b1, 8'h04, 32'hFFFF_FFFF, 4'h1);
        rd(8'h04, {16'h0000, v[15:8], 8'hFF});
        wr(8'h1C, 32'hFFFF);
        rd(8'h1C, 32'h0);
        $display("test registers done");
        wr(8'h0C, 32'h0);
        wr(8'h08, 32'h0846);
        wr(8'h04, 32'hFFFE);
        wr(8'h00, 32'h0046);
        u_sen.pulse_a(3);
        rd(8'h04, 32'h0001);
        rd(8'h18, 32'h0001);
        check(toggle_latch_pin_o, 32'h0);
        rd(8'h0C, 32'h0001);
        wr(8'h00, 32'h004E);
        u_sen.pulse_a(3);
        rd(8'h04, 32'hFFFE);
        rd(8'h18, 32'h0000);
        rd(8'h0C, 32'h0001);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h0056);
        u_sen.set_pins(1'b0, 1'b1, 1'b0);
        u_sen.pulse_a(2);
        rd(8'h04, 32'hFFFC);
        rd(8'h18, 32'h0004);
        u_sen.set_pins(1'b0, 1'b0, 1'b0);
        $display("test event counting done");
        wr(8'h04, 32'h0100);
        wr(8'h00, 32'h0007);
        u_sen.quad(4);
        rd(8'h04, 32'h0104);
        u_sen.quad(-2);
        rd(8'h04, 32'h0102);
        wr(8'h00, 32'h0);
        u_sen.set_pins(1'b0, 1'b0, 1'b0);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0025);
        repeat (200) @(posedge clk_i);
        rd(8'h04, 32'h0);
        u_sen.set_pins(1'b1, 1'b0, 1'b0);
        repeat (100) @(posedge clk_i);
        rd(8'h04, 32'h0, 1'b0);
        check(32'(rv[15:0] != 16'h0), 32'h1);
        u_sen.set_pins(1'b0, 1'b0, 1'b0);
        $display("test quadrature and gate done");
        for (int p = 0; p < 3; p++) begin
            wr(8'h04, 32'h0);
            wr(8'h00, 32'h4 | (p << 8));
            repeat ((400 << p) - 2) @(posedge clk_i);
            wr(8'h00, 32'h0);
            rd(8'h04, 32'h0, 1'b0);
            check(32'(rv[15:0] >= 99 && rv[15:0] <= 101), 32'h1);
        end
        $display("test prescaler done");
        wr(8'h04, 32'h1234);
        wr(8'h10, 32'h1084);
        wr(8'h14, 32'h0);
        u_sen.pulse_aux();
        repeat (100) @(posedge clk_i);
        rd(8'h14, 32'h1234);
        wr(8'h10, 32'h6004);
        wr(8'h14, 32'h00AA);
        wr(8'h04, 32'h0555);
        u_sen.pulse_aux();
        rd(8'h04, 32'h00AA);
        rd(8'h14, 32'h00AA);
        $display("test capture and reload done");
        wr(8'h08, 32'hA000);
        wr(8'h0C, 32'hFFF0);
        wr(8'h10, 32'hE000);
        wr(8'h14, 32'hFFF8);
        wr(8'h04, 32'hFFF0);
        wr(8'h00, 32'h1004);
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        check(n, 32'd64);
        wait_pin(1'b1, n);
        check(n, 32'd32);
        $display("test pwm done");
        close_out();
    end
endmodule
